// ==== pwp_pkg.sv ====
// Purpose: shared constants and types of the peripheral write-protect bank
// Assumes: 32-bit APB register bus, one protect bit per peripheral on the bridge
// Notes: protect_clear and protect_set are two views of one protection state
//
// Functional notes
// - a protect bit written with zero leaves that peripheral's protection unchanged
// - a one written to protect_clear unprotects the peripheral; it reads the protection state
// - protect_set sits at offset 0x04 and resets to 0x00800000
// - timer units 0..7 own bits 8..15 in ascending order, read/write
// - serial units 0..5 own bits 2..7 in ascending order, read/write
// - a one to protect_set protects; both views read the same state
// - a write to a protected peripheral is discarded and returns an error
// - protecting twice or unprotecting twice answers the bus with an error
package pwp_pkg;

    // register byte offsets
    localparam logic [11:0] PWP_OFF_CLEAR = 12'h000;
    localparam logic [11:0] PWP_OFF_SET = 12'h004;
    localparam logic [11:0] PWP_OFF_STATUS = 12'h008;
    localparam logic [11:0] PWP_OFF_MASK = 12'h00C;

    // protection state layout
    localparam logic [31:0] PWP_PROT_RESET = 32'h0080_0000;
    localparam int PWP_EVENT_BIT = 1;
    localparam int PWP_SERIAL_LSB = 2;
    localparam int PWP_SERIAL_CNT = 6;
    localparam int PWP_TIMER_LSB = 8;
    localparam int PWP_TIMER_CNT = 8;
    localparam int PWP_ANALOG_LSB = 16;
    localparam int PWP_ANALOG_CNT = 3;
    localparam int PWP_TOUCH_BIT = 19;
    localparam logic [31:0] PWP_PROT_WRITABLE = 32'h000F_FFFE;

    // interrupt status and mask layout
    localparam int PWP_EV_REFUSED = 0;
    localparam int PWP_EV_DOUBLE = 1;
    localparam logic [1:0] PWP_EV_RESET = 2'h0;
    localparam logic [31:0] PWP_ZERO_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        PWP_ST_IDLE = 2'b01,
        PWP_ST_ACCESS = 2'b10
    } pwp_apb_state_t;

    // write aimed at a guarded peripheral
    typedef struct packed {
        logic [4:0] target;
        logic [31:0] data;
    } pwp_wreq_t;

    // expand byte strobes into a bit mask
    function automatic logic [31:0] pwp_lane_mask(input logic [3:0] strb);
        pwp_lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

endpackage

// ==== pwp_guard.sv ====
// Purpose: refuses writes aimed at write-protected peripherals
// Assumes: one write request at most per cycle, target is the protect bit index
// Notes: answer appears one cycle after the request
`timescale 1ns/1ps
module pwp_guard (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // request from the bridge
    input wire logic acc_valid,
    input wire pwp_pkg::pwp_wreq_t acc_req,
    input wire logic [31:0] prot_state,
    // forwarded write or refusal
    output logic fwd_valid_reg,
    output pwp_pkg::pwp_wreq_t fwd_req_reg,
    output logic acc_error_reg
);

    logic blocked;

    assign blocked = prot_state[acc_req.target];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fwd_valid_reg <= 1'b0;
            acc_error_reg <= 1'b0;
        end else begin
            fwd_valid_reg <= acc_valid && !blocked;
            acc_error_reg <= acc_valid && blocked;
        end
    end

    // refused data never reaches the peripheral side
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fwd_req_reg <= '0;
        end else if (acc_valid && !blocked) begin
            fwd_req_reg <= acc_req;
        end
    end

    chk_refuse_protected: assert property (@(posedge clk) disable iff (!reset_n)
        (acc_valid && blocked) |=> (acc_error_reg && !fwd_valid_reg))
        else $error("write to protected peripheral was not refused");

endmodule

// ==== pwp_ctrl.sv ====
// Purpose: peripheral write-protect bank with APB register access
// Assumes: APB master holds the request until pready; one clock, async reset
// Notes: every access takes one wait-free access phase; errors use pslverr
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module pwp_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // guarded peripheral writes
    input wire logic acc_valid,
    input wire pwp_pkg::pwp_wreq_t acc_req,
    output logic fwd_valid,
    output pwp_pkg::pwp_wreq_t fwd_req,
    output logic acc_error,
    // protection state and interrupt
    output logic [31:0] prot_state,
    output logic irq
);

    pwp_pkg::pwp_apb_state_t state_reg;
    logic [31:0] prot_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic pready_reg;
    logic [31:0] prdata_next;
    logic pslverr_next;
    logic setup_phase;
    logic wr_done;
    logic [31:0] wbits;
    logic hit_clear;
    logic hit_set;
    logic hit_status;
    logic hit_mask;
    logic double_err;
    logic guard_refused;
    logic [1:0] status_next;

    assign setup_phase = psel && !penable;
    assign wr_done = (state_reg == pwp_pkg::PWP_ST_ACCESS) && psel && penable && pwrite;
    assign wbits = pwdata & pwp_pkg::pwp_lane_mask(pstrb) & pwp_pkg::PWP_PROT_WRITABLE;

    always_comb begin
        hit_clear = 1'b0;
        hit_set = 1'b0;
        hit_status = 1'b0;
        hit_mask = 1'b0;
        if (paddr == pwp_pkg::PWP_OFF_CLEAR) begin
            hit_clear = 1'b1;
        end else if (paddr == pwp_pkg::PWP_OFF_SET) begin
            hit_set = 1'b1;
        end else if (paddr == pwp_pkg::PWP_OFF_STATUS) begin
            hit_status = 1'b1;
        end else if (paddr == pwp_pkg::PWP_OFF_MASK) begin
            hit_mask = 1'b1;
        end
    end

    assign double_err = pwrite && ((hit_set && ((wbits & prot_reg) != pwp_pkg::PWP_ZERO_WORD))
        || (hit_clear && ((wbits & ~prot_reg) != pwp_pkg::PWP_ZERO_WORD)));

    // answer prepared in the setup cycle, shown in the access cycle
    always_comb begin
        prdata_next = pwp_pkg::PWP_ZERO_WORD;
        pslverr_next = 1'b0;
        if (hit_clear || hit_set) begin
            prdata_next = prot_reg;
            pslverr_next = double_err;
        end else if (hit_status) begin
            prdata_next = {30'h0, status_reg};
        end else if (hit_mask) begin
            prdata_next = {30'h0, mask_reg};
        end else begin
            // unmapped offsets answer with an error
            pslverr_next = 1'b1;
        end
        if (pwrite) begin
            prdata_next = pwp_pkg::PWP_ZERO_WORD;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= pwp_pkg::PWP_ST_IDLE;
        end else begin
            case (state_reg)
                pwp_pkg::PWP_ST_IDLE: begin
                    if (setup_phase) begin
                        state_reg <= pwp_pkg::PWP_ST_ACCESS;
                    end
                end
                pwp_pkg::PWP_ST_ACCESS: begin
                    state_reg <= pwp_pkg::PWP_ST_IDLE;
                end
                default: begin
                    state_reg <= pwp_pkg::PWP_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= pwp_pkg::PWP_ZERO_WORD;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end else if (state_reg == pwp_pkg::PWP_ST_IDLE && setup_phase) begin
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            // ready from its own flop, not a state decode
            pready_reg <= 1'b1;
        end else begin
            prdata_reg <= pwp_pkg::PWP_ZERO_WORD;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end
    end

    // protection state: writes take effect at the completing edge only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prot_reg <= pwp_pkg::PWP_PROT_RESET;
        end else if (wr_done && hit_set) begin
            prot_reg <= prot_reg | wbits;
        end else if (wr_done && hit_clear) begin
            prot_reg <= prot_reg & ~wbits;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= pwp_pkg::PWP_EV_RESET;
        end else if (wr_done && hit_mask && pstrb[0]) begin
            mask_reg <= pwdata[1:0];
        end
    end

    // sticky events: a new event beats a same-cycle clear
    always_comb begin
        status_next = status_reg;
        if (wr_done && hit_status && pstrb[0]) begin
            status_next = status_reg & ~pwdata[1:0];
        end
        if (guard_refused) begin
            status_next[pwp_pkg::PWP_EV_REFUSED] = 1'b1;
        end
        if (wr_done && double_err) begin
            status_next[pwp_pkg::PWP_EV_DOUBLE] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= pwp_pkg::PWP_EV_RESET;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    pwp_guard u_guard (
        .clk(clk),
        .reset_n(reset_n),
        .acc_valid(acc_valid),
        .acc_req(acc_req),
        .prot_state(prot_reg),
        .fwd_valid_reg(fwd_valid),
        .fwd_req_reg(fwd_req),
        .acc_error_reg(guard_refused)
    );

    assign acc_error = guard_refused;
    assign prot_state = prot_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign pready = pready_reg;
    assign irq = irq_reg;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    logic seen_write;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_write <= 1'b0;
        end else if (wr_done) begin
            seen_write <= 1'b1;
        end
    end

    sequence seq_setup_write(logic hit);
        setup_phase && pwrite && hit && (state_reg == pwp_pkg::PWP_ST_IDLE);
    endsequence

    sequence seq_access_done;
        pready && psel && penable;
    endsequence

    chk_zero_no_effect: assert property (
        (wr_done && (hit_clear || hit_set) && wbits == pwp_pkg::PWP_ZERO_WORD) |=> $stable(prot_reg))
        else $error("zero write changed protection state");

    chk_clear_unprotects: assert property (
        (wr_done && hit_clear) |=> ((prot_reg & $past(wbits)) == pwp_pkg::PWP_ZERO_WORD))
        else $error("clear write left a bit protected");

    chk_reset_value: assert property (
        !seen_write |-> (prot_reg == pwp_pkg::PWP_PROT_RESET))
        else $error("protection state differs from reset value");

    chk_timer_bits: assert property (
        (wr_done && hit_set) |=> ((prot_reg[15:8] & $past(wbits[15:8])) == $past(wbits[15:8])))
        else $error("timer protect bits not set");

    chk_serial_bits: assert property (
        (wr_done && hit_set) |=> ((prot_reg[7:2] & $past(wbits[7:2])) == $past(wbits[7:2])))
        else $error("serial protect bits not set");

    chk_views_match: assert property (
        (setup_phase && !pwrite && (hit_clear || hit_set) && state_reg == pwp_pkg::PWP_ST_IDLE)
        |=> (prdata == $past(prot_reg)) and seq_access_done)
        else $error("protect views read a wrong state");

    chk_double_error: assert property (
        (seq_setup_write(hit_set || hit_clear) and double_err) |=> (pslverr && pready) ##1 status_reg[1])
        else $error("double protect or unprotect not reported");

    chk_fixed_bits: assert property (
        ((prot_reg & ~pwp_pkg::PWP_PROT_WRITABLE) == (pwp_pkg::PWP_PROT_RESET & ~pwp_pkg::PWP_PROT_WRITABLE)))
        else $error("fixed protect bit changed");

    chk_irq_follows: assert property (
        (guard_refused && mask_reg[0]) |=> ##[0:1] irq)
        else $error("masked-in event did not raise interrupt");

    // an allowed guard request is passed on one cycle later
    chk_fwd_allowed: assert property (
        (acc_valid && !prot_reg[acc_req.target]) |=> (fwd_valid && !acc_error && fwd_req == $past(acc_req)))
        else $error("allowed peripheral write was not forwarded");

    chk_refused_status: assert property (
        guard_refused |=> status_reg[pwp_pkg::PWP_EV_REFUSED])
        else $error("refused write did not set its status bit");

    chk_set_protects: assert property (
        (wr_done && hit_set) |=> ((prot_reg & $past(wbits)) == $past(wbits)))
        else $error("set write left a bit unprotected");

    chk_set_keeps_rest: assert property (
        (wr_done && hit_set) |=> ((prot_reg & ~$past(wbits)) == ($past(prot_reg) & ~$past(wbits))))
        else $error("set write changed a bit written with zero");

    chk_clear_keeps_rest: assert property (
        (wr_done && hit_clear) |=> ((prot_reg | $past(wbits)) == ($past(prot_reg) | $past(wbits))))
        else $error("clear write changed a bit written with zero");

    // an address outside the map answers with an error and zero data
    sequence seq_setup_unmapped;
        setup_phase && (state_reg == pwp_pkg::PWP_ST_IDLE) && !(hit_clear || hit_set || hit_status || hit_mask);
    endsequence

    sequence seq_error_answer;
        pready && pslverr && (prdata == pwp_pkg::PWP_ZERO_WORD);
    endsequence

    chk_unmapped_error: assert property (
        seq_setup_unmapped |=> seq_error_answer)
        else $error("unmapped access was not refused");

    chk_write_reads_zero: assert property (
        seq_setup_write(1'b1) |=> (prdata == pwp_pkg::PWP_ZERO_WORD))
        else $error("write answer carried read data");

    // the answer stands for the access cycle only
    chk_pready_single: assert property (
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    chk_answer_idle: assert property (
        !pready |-> (prdata == pwp_pkg::PWP_ZERO_WORD && !pslverr))
        else $error("answer shown outside the access cycle");

    // a same-cycle event beats the clear, so only quiet cycles are checked
    chk_status_clear: assert property (
        (wr_done && hit_status && pstrb[0] && !guard_refused) |=> ((status_reg & $past(pwdata[1:0])) == 2'h0))
        else $error("status bit survived its clear");

    // irq sees the mask of the cycle before
    chk_irq_level: assert property (
        1'b1 |=> (irq == (|(status_reg & $past(mask_reg)))))
        else $error("interrupt differs from unmasked status");

endmodule

// ==== pwp_cpu_model.sv ====
// Purpose: processor-side apb master driving the write-protect bank
// Assumes: one transfer at a time, answer sampled at rising edges
// Notes: address and data are scrambled while the bus is idle
`timescale 1ns/1ps
module pwp_cpu_model (
    // clock
    input wire logic clk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // ok stays low when the slave never answers
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            ok = (pready === 1'b1);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ==== peripheral_write_protect_tb_top.sv ====
// Purpose: self-checking bench of the write-protect bank
// Assumes: answers are compared by monitors against queued notes
// Notes: random data comes from a small lfsr seeded at 35
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module peripheral_write_protect_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, acc_valid, fwd_valid, acc_error, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, prot_state;
    logic [3:0] pstrb;
    pwp_pkg::pwp_wreq_t acc_req, fwd_req;
    logic [32:0] q_apb[$];
    logic [37:0] q_acc[$];
    logic [32:0] ea;
    logic [37:0] eg;
    logic [31:0] mp = 32'h0080_0000;
    logic [31:0] lf = 32'h0000_0023;
    logic [1:0] st = 2'h0;
    logic [1:0] mk = 2'h0;
    int mismatches = 0;
    int samples_checked = 0;

    always #50 clk = ~clk;

    pwp_cpu_model P (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
    pwp_ctrl DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_valid(acc_valid), .acc_req(acc_req), .fwd_valid(fwd_valid),
        .fwd_req(fwd_req), .acc_error(acc_error), .prot_state(prot_state), .irq(irq));

    always @(posedge clk) begin
        if (pready === 1'b1) begin
            ea = q_apb.pop_front();
            `CHK({pslverr, prdata}, ea)
        end
        if (fwd_valid === 1'b1 || acc_error === 1'b1) begin
            eg = q_acc.pop_front();
            `CHK({acc_error, fwd_valid}, {eg[37], ~eg[37]})
            if (!eg[37]) `CHK(fwd_req, eg[36:0])
        end
    end

    function automatic logic [31:0] nxt(input logic [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic conclude();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [31:0] ed, input logic ee);
        bit ok;
        q_apb.push_back({ee, ed});
        P.xfer(w, a, d, s, ok);
        if (!ok) begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        // state written at the last edge settles before it is looked at
        @(negedge clk);
        `CHK(prot_state, mp)
        apb(1'b0, a, 32'h0000_0000, 4'hF, e, 1'b0);
    endtask

    // writable bits 19..1 only, gated by byte lanes
    task automatic wr_prot(input logic clr, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        logic dbl;
        m = d & 32'h000F_FFFE & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        dbl = clr ? |(m & ~mp) : |(m & mp);
        apb(1'b1, clr ? pwp_pkg::PWP_OFF_CLEAR : pwp_pkg::PWP_OFF_SET, d, s, 32'h0000_0000, dbl);
        mp = clr ? (mp & ~m) : (mp | m);
        st[1] = st[1] | dbl;
    endtask

    task automatic grd(input logic [4:0] t, input logic [31:0] d);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_req <= '{target: t, data: d};
        q_acc.push_back({mp[t], t, d});
        st[0] = st[0] | mp[t];
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_req <= '{target: ~t, data: ~d};
    endtask

    task automatic irq_chk();
        repeat (3) @(posedge clk);
        `CHK(irq, |(st & mk))
    endtask

    initial begin
        acc_valid = 1'b0;
        acc_req = '0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(pwp_pkg::PWP_OFF_CLEAR, 32'h0080_0000);
        rd(pwp_pkg::PWP_OFF_SET, 32'h0080_0000);
        rd(pwp_pkg::PWP_OFF_STATUS, 32'h0000_0000);
        apb(1'b1, pwp_pkg::PWP_OFF_MASK, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, 1'b0);
        mk = 2'h3;
        rd(pwp_pkg::PWP_OFF_MASK, 32'h0000_0003);
        for (int i = 0; i < 32; i++) begin
            wr_prot(1'b0, 32'h0000_0001 << i, 4'hF);
            rd(pwp_pkg::PWP_OFF_CLEAR, mp);
        end
        for (int i = 0; i < 32; i++) begin
            wr_prot(1'b0, 32'h0000_0001 << i, 4'hF);
        end
        irq_chk();
        rd(pwp_pkg::PWP_OFF_STATUS, {30'h0, st});
        apb(1'b1, pwp_pkg::PWP_OFF_STATUS, 32'h0000_0003, 4'hF, 32'h0000_0000, 1'b0);
        st = 2'h0;
        irq_chk();
        for (int i = 0; i < 40; i++) begin
            lf = nxt(lf);
            grd(lf[4:0], lf);
            lf = nxt(lf);
            wr_prot(lf[31], lf, lf[3:0]);
        end
        irq_chk();
        rd(pwp_pkg::PWP_OFF_STATUS, {30'h0, st});
        wr_prot(1'b1, 32'hFFFF_FFFF, 4'hF);
        rd(pwp_pkg::PWP_OFF_SET, 32'h0080_0000);
        wr_prot(1'b1, 32'h0000_0100, 4'hF);
        wr_prot(1'b0, 32'h0000_0000, 4'hF);
        wr_prot(1'b1, 32'h0000_0000, 4'hF);
        wr_prot(1'b0, 32'hFFFF_FFFF, 4'h2);
        rd(pwp_pkg::PWP_OFF_SET, 32'h0080_FF00);
        apb(1'b1, 12'h010, lf, 4'hF, 32'h0000_0000, 1'b1);
        apb(1'b0, 12'h010, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'b1);
        apb(1'b1, pwp_pkg::PWP_OFF_MASK, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'b0);
        mk = 2'h0;
        grd(5'd8, lf);
        grd(5'd2, ~lf);
        irq_chk();
        rd(pwp_pkg::PWP_OFF_STATUS, {30'h0, st});
        // let the monitor take the last answer off its queue first
        @(negedge clk);
        `CHK(q_apb.size() + q_acc.size(), 0)
        conclude();
    end
endmodule
